// *** hw/lscp_config_pins.sv ***
// The strobed register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "lscp_defines.svh"

module lscp_config_pins #(
    parameter int SYNC_STAGES = `LSCP_SYNC_STAGES
) (
    input wire logic clock,
    input wire logic external_reset_n,
    // Status from the transceiver core, same clock domain.
    input wire lscp_pkg::lscp_status_t coreStatus,
    // Shared indicator / address pins, bit 0 speed, 1 link, 2 activity,
    // 3 duplex.
    input wire logic [3:0] indicatorIn,
    output logic [3:0] indicatorOut,
    output logic [3:0] indicatorOeN,
    // Shared general output one / address bit 4 pin.
    input wire logic generalOutputOneIn,
    output logic generalOutputOneOut,
    output logic generalOutputOneOeN,
    // Dedicated strap inputs.
    input wire logic [2:0] modeStrapIn,
    input wire logic crossoverEnableStrapIn,
    input wire logic regulatorStrapIn,
    // Register port.
    input wire logic [`LSCP_ADDR_WIDTH-1:0] regAddr,
    input wire logic [`LSCP_DATA_WIDTH-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [`LSCP_DATA_WIDTH-1:0] regRdata,
    // Captured defaults and effective settings for the core.
    output lscp_pkg::lscp_straps_t defaults,
    output logic crossoverEnable,
    output logic regulatorEnable
);

    // The settle counter is three bits wide, which caps the stage count.
    if (SYNC_STAGES < 2 || SYNC_STAGES > 7) begin
        $error("lscp_config_pins supports two to seven sync stages");
    end

    localparam int PIN_COUNT = 10;

    // The capture copies the synchroniser straight into the defaults
    // struct, so both must agree bit for bit.
    if ($bits(lscp_pkg::lscp_straps_t) != PIN_COUNT) begin
        $error("lscp_config_pins strap struct does not match the pins");
    end

    // Both stored control bits must fall inside the register word.
    if (`LSCP_XOVR_OVR_BIT >= `LSCP_DATA_WIDTH
        || `LSCP_GENERAL_OUTPUT_ONE_BIT >= `LSCP_DATA_WIDTH) begin
        $error("lscp_config_pins control bit outside the register word");
    end

    logic [PIN_COUNT-1:0] pinsRaw;
    logic [PIN_COUNT-1:0] pinsSync;

    // Pins stay undriven during the settle phase, so board straps set
    // their level while the synchroniser fills.
    assign pinsRaw = {regulatorStrapIn, crossoverEnableStrapIn,
                      modeStrapIn, generalOutputOneIn, indicatorIn};

    lscp_sync #(
        .WIDTH(PIN_COUNT),
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .clock(clock),
        .external_reset_n(external_reset_n),
        .asyncIn(pinsRaw),
        .syncOut(pinsSync)
    );

    // Capture phase after reset release.
    lscp_pkg::lscp_phase_t phase_reg;
    lscp_pkg::lscp_phase_t phase_next;
    logic [2:0] settleCount_reg;
    logic [2:0] settleCount_next;
    lscp_pkg::lscp_straps_t straps_reg;
    lscp_pkg::lscp_straps_t straps_next;

    always_comb begin
        phase_next = phase_reg;
        settleCount_next = settleCount_reg;
        straps_next = straps_reg;
        case (phase_reg)
            lscp_pkg::LSCP_SETTLE: begin
                if (settleCount_reg == 3'(SYNC_STAGES)) begin
                    // The synchroniser now holds levels seen after release.
                    straps_next.addr = pinsSync[4:0];
                    straps_next.mode = pinsSync[7:5];
                    straps_next.crossoverStrap = pinsSync[8];
                    straps_next.regulatorStrap = pinsSync[9];
                    phase_next = lscp_pkg::LSCP_RUN;
                end else begin
                    settleCount_next = settleCount_reg + 3'h1;
                end
            end
            lscp_pkg::LSCP_RUN: begin
                // Defaults hold unchanged until the next reset.
                phase_next = lscp_pkg::LSCP_RUN;
            end
            default: begin
                phase_next = lscp_pkg::LSCP_SETTLE;
                settleCount_next = 3'h0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge external_reset_n) begin
        if (!external_reset_n) begin
            phase_reg <= lscp_pkg::LSCP_SETTLE;
            settleCount_reg <= 3'h0;
            straps_reg <= `LSCP_STRAPS_RESET;
        end else begin
            phase_reg <= phase_next;
            settleCount_reg <= settleCount_next;
            straps_reg <= straps_next;
        end
    end

    // Register file.
    logic [`LSCP_DATA_WIDTH-1:0] gpctrl_reg;
    logic [`LSCP_DATA_WIDTH-1:0] gpctrl_next;
    logic [`LSCP_DATA_WIDTH-1:0] rdata_reg;
    logic [`LSCP_DATA_WIDTH-1:0] rdata_next;
    logic [`LSCP_DATA_WIDTH-1:0] statusWord;
    logic [`LSCP_DATA_WIDTH-1:0] gpctrlMask;

    // Only the override bit and the output one bit are stored.
    assign gpctrlMask = (`LSCP_DATA_WIDTH'(1) << `LSCP_XOVR_OVR_BIT)
                      | (`LSCP_DATA_WIDTH'(1) << `LSCP_GENERAL_OUTPUT_ONE_BIT);

    always_comb begin
        gpctrl_next = gpctrl_reg;
        if (regWrite && regAddr == `LSCP_REG_GPCTRL) begin
            gpctrl_next = regWdata & gpctrlMask;
        end
    end

    // Read data is zero outside its answer cycle, so nothing stale lingers.
    always_comb begin
        rdata_next = '0;
        if (regRead) begin
            case (regAddr)
                `LSCP_REG_GPCTRL: rdata_next = gpctrl_reg;
                `LSCP_REG_STATUS: rdata_next = statusWord;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge external_reset_n) begin
        if (!external_reset_n) begin
            gpctrl_reg <= `LSCP_GPCTRL_RESET;
            rdata_reg <= '0;
        end else begin
            gpctrl_reg <= gpctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    assign regRdata = rdata_reg;

    // Pin drivers and effective settings.
    logic [3:0] ledOut_reg;
    logic [3:0] ledOut_next;
    logic [3:0] ledOeN_reg;
    logic [3:0] ledOeN_next;
    logic gpoOut_reg;
    logic gpoOut_next;
    logic gpoOeN_reg;
    logic gpoOeN_next;
    logic xovrEn_reg;
    logic xovrEn_next;

    always_comb begin
        ledOut_next = 4'h0;
        ledOeN_next = 4'hf;
        gpoOut_next = 1'b0;
        gpoOeN_next = 1'b1;
        if (phase_reg == lscp_pkg::LSCP_RUN) begin
            ledOut_next[0] = coreStatus.speed_led;
            ledOut_next[1] = coreStatus.linkUp;
            ledOut_next[2] = coreStatus.carrierSense;
            ledOut_next[3] = coreStatus.fullDuplex;
            ledOeN_next = 4'h0;
            gpoOut_next = gpctrl_reg[`LSCP_GENERAL_OUTPUT_ONE_BIT];
            gpoOeN_next = 1'b0;
        end
        // A set override bit turns automatic crossover off.
        // A strap tied low keeps crossover off whatever software writes.
        xovrEn_next = straps_reg.crossoverStrap
                    & ~gpctrl_reg[`LSCP_XOVR_OVR_BIT];
    end

    always_ff @(posedge clock or negedge external_reset_n) begin
        if (!external_reset_n) begin
            ledOut_reg <= 4'h0;
            ledOeN_reg <= 4'hf;
            gpoOut_reg <= 1'b0;
            gpoOeN_reg <= 1'b1;
            xovrEn_reg <= 1'b0;
        end else begin
            ledOut_reg <= ledOut_next;
            ledOeN_reg <= ledOeN_next;
            gpoOut_reg <= gpoOut_next;
            gpoOeN_reg <= gpoOeN_next;
            xovrEn_reg <= xovrEn_next;
        end
    end

    assign statusWord = {1'b0, ledOut_reg, xovrEn_reg,
                         straps_reg.regulatorStrap, straps_reg.crossoverStrap,
                         straps_reg.mode, straps_reg.addr};

    assign indicatorOut = ledOut_reg;
    assign indicatorOeN = ledOeN_reg;
    assign generalOutputOneOut = gpoOut_reg;
    assign generalOutputOneOeN = gpoOeN_reg;
    assign defaults = straps_reg;
    assign crossoverEnable = xovrEn_reg;
    assign regulatorEnable = straps_reg.regulatorStrap;

endmodule

`default_nettype wire

// *** hw/lscp_defines.svh ***
// Functional notes
// - Speed indicator is active at 100 megabit and inactive at 10 megabit.
// - Link indicator is active whenever a link is up at either rate.
// - Activity indicator follows carrier sense of the active medium.
// - Duplex indicator is active in full duplex and inactive in half duplex.
// - Address bits 0-3 come from indicator pins, bit 4 from output one pin.
// - Default operating mode is a 3-bit field from three mode straps.
// - Crossover detection on when its strap is high or floating, off if low.
// - Software may override the crossover strap through register 27 bit 15.
// - Regulator strap sampled at power-on; high turns the core regulator on.
// - All strap levels are captured at reset release and used as defaults.
`ifndef LSCP_DEFINES_SVH
`define LSCP_DEFINES_SVH

`define LSCP_ADDR_WIDTH 5
`define LSCP_DATA_WIDTH 16
`define LSCP_SYNC_STAGES 2

`define LSCP_REG_GPCTRL 5'h1b
`define LSCP_REG_STATUS 5'h10

`define LSCP_XOVR_OVR_BIT 15
`define LSCP_GENERAL_OUTPUT_ONE_BIT 0
`define LSCP_GPCTRL_RESET 16'h0000

`define LSCP_STRAPS_RESET 10'h000

`endif

// *** hw/lscp_pkg.sv ***
`default_nettype none

package lscp_pkg;

    typedef struct packed {
        logic fullDuplex;
        logic carrierSense;
        logic linkUp;
        logic speed_led;
    } lscp_status_t;

    typedef struct packed {
        logic regulatorStrap;
        logic crossoverStrap;
        logic [2:0] mode;
        logic [4:0] addr;
    } lscp_straps_t;

    typedef enum {
        LSCP_SETTLE,
        LSCP_RUN
    } lscp_phase_t;

endpackage

`default_nettype wire

// *** hw/lscp_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module lscp_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = 2
) (
    input wire logic clock,
    input wire logic external_reset_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    if (STAGES < 2 || WIDTH < 1) begin
        $error("lscp_sync needs at least two stages and one bit");
    end

    logic [WIDTH-1:0] stage_reg [STAGES];
    logic [WIDTH-1:0] stage_next [STAGES];

    // Only the next stage looks at each stage but the last, which drives syncOut; nothing taps the first one.
    always_comb begin
        stage_next[0] = asyncIn;
        for (int i = 1; i < STAGES; i++) begin
            stage_next[i] = stage_reg[i-1];
        end
    end

    always_ff @(posedge clock or negedge external_reset_n) begin
        if (!external_reset_n) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < STAGES; i++) begin
                stage_reg[i] <= stage_next[i];
            end
        end
    end

    assign syncOut = stage_reg[STAGES-1];

endmodule

`default_nettype wire

// *** verif/lscp_config_pins_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module lscp_config_pins_chk (
    input wire logic clock,
    input wire logic external_reset_n,
    input wire lscp_pkg::lscp_status_t coreStatus,
    input wire logic [3:0] indicatorOut,
    input wire logic [3:0] indicatorOeN,
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire lscp_pkg::lscp_straps_t defaults,
    input wire logic crossoverEnable,
    input wire logic regulatorEnable
);
    logic run;
    assign run = indicatorOeN == 4'h0;
    default clocking @(posedge clock); endclocking
    default disable iff (!external_reset_n);
    sequence s_on; run && $past(run); endsequence
    property p_spd; s_on |-> indicatorOut[0] == $past(coreStatus[0]);
    endproperty
    a_spd: assert property (p_spd) else $error("speed lamp off");
    property p_lnk; s_on |-> indicatorOut[1] == $past(coreStatus[1]);
    endproperty
    a_lnk: assert property (p_lnk) else $error("link lamp off");
    property p_act; s_on |-> indicatorOut[2] == $past(coreStatus[2]);
    endproperty
    a_act: assert property (p_act) else $error("activity lamp off");
    property p_dup; s_on |-> indicatorOut[3] == $past(coreStatus[3]);
    endproperty
    a_dup: assert property (p_dup) else $error("duplex lamp off");
    property p_rst; $rose(external_reset_n) |-> indicatorOeN == 4'hf
        && indicatorOut == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("driven in reset");
    property p_hold; run |=> run && $stable(defaults); endproperty
    a_hold: assert property (p_hold) else $error("defaults moved");
    property p_xo; regWrite && regAddr == 5'h1b && run |-> ##2
        crossoverEnable
            == (defaults.crossoverStrap && !$past(regWdata[15], 2));
    endproperty
    a_xo: assert property (p_xo) else $error("crossover wrong");
    // The regulator setting is taken once per reset and must not follow
    // the strap pin afterwards.
    property p_reg; run |-> regulatorEnable == defaults.regulatorStrap
        && $stable(regulatorEnable);
    endproperty
    a_reg: assert property (p_reg) else $error("regulator wrong");
    c_run: cover property ($rose(run));
    c_ovr: cover property (run && defaults.crossoverStrap && !crossoverEnable);
    c_all: cover property (s_on and (indicatorOut == 4'hf));
endmodule
bind lscp_config_pins lscp_config_pins_chk chk (.clock, .external_reset_n, .coreStatus,
    .indicatorOut, .indicatorOeN, .regAddr, .regWdata, .regWrite,
    .defaults, .crossoverEnable, .regulatorEnable);
`default_nettype wire

// *** verif/lscp_board_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module lscp_board_model (
    input wire lscp_pkg::lscp_straps_t straps,
    input wire logic [3:0] indicatorOut,
    input wire logic [3:0] indicatorOeN,
    input wire logic generalOutputOneOut,
    input wire logic generalOutputOneOeN,
    output logic [3:0] indicatorIn,
    output logic generalOutputOneIn,
    output logic [2:0] modeStrapIn,
    output logic crossoverEnableStrapIn,
    output logic regulatorStrapIn
);
    // A released pin falls back to its strap resistor, never to the last drive.
    assign indicatorIn = (indicatorOut & ~indicatorOeN)
        | (straps.addr[3:0] & indicatorOeN);
    assign generalOutputOneIn = generalOutputOneOeN ? straps.addr[4]
        : generalOutputOneOut;
    assign modeStrapIn = straps.mode;
    // A floating crossover strap is modelled as its pull-up level.
    assign crossoverEnableStrapIn = straps.crossoverStrap;
    assign regulatorStrapIn = straps.regulatorStrap;
endmodule
`default_nettype wire

// *** verif/tb_led_strap_config_pins.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_led_strap_config_pins;
    logic clock, external_reset_n, gpIn, gpOut, gpOeN, xoStrap, regStrap;
    logic regWrite, regRead, crossoverEnable, regulatorEnable;
    lscp_pkg::lscp_status_t coreStatus;
    lscp_pkg::lscp_straps_t straps, defaults;
    lscp_pkg::lscp_straps_t pat [3] = '{10'h2b5, 10'h14a, 10'h3ff};
    logic [3:0] indicatorIn, indicatorOut, indicatorOeN;
    logic [2:0] modeStrap;
    logic [4:0] regAddr;
    logic [15:0] regWdata, regRdata;
    int failCount = 0;
    int compares = 0;
    lscp_config_pins dut (.clock, .external_reset_n, .coreStatus, .indicatorIn,
        .indicatorOut, .indicatorOeN, .generalOutputOneIn(gpIn),
        .generalOutputOneOut(gpOut), .generalOutputOneOeN(gpOeN),
        .modeStrapIn(modeStrap), .crossoverEnableStrapIn(xoStrap),
        .regulatorStrapIn(regStrap), .regAddr, .regWdata, .regWrite,
        .regRead, .regRdata, .defaults, .crossoverEnable, .regulatorEnable);
    lscp_board_model board (.straps, .indicatorOut, .indicatorOeN,
        .generalOutputOneOut(gpOut), .generalOutputOneOeN(gpOeN),
        .indicatorIn, .generalOutputOneIn(gpIn), .modeStrapIn(modeStrap),
        .crossoverEnableStrapIn(xoStrap), .regulatorStrapIn(regStrap));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic reportAndStop;
        $display("compares %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        chk(regRdata, exp);
    endtask
    // Each pass after the first resets in mid-run, so the capture is proven per reset.
    task automatic boot(input lscp_pkg::lscp_straps_t s);
        int n;
        @(posedge clock);
        external_reset_n <= 1'b0;
        straps <= s;
        coreStatus <= 4'h0;
        repeat (8) @(posedge clock);
        chk({indicatorOut, indicatorOeN, gpOeN}, 9'h01f);
        repeat (8) @(posedge clock);
        external_reset_n <= 1'b1;
        for (n = 0; n < 20 && indicatorOeN !== 4'h0; n++) @(negedge clock);
        if (n == 20) begin
            failCount++;
            reportAndStop();
        end
    endtask
    initial begin
        external_reset_n = 1'b0;
        coreStatus = 4'h0;
        straps = 10'h000;
        regAddr = 5'h00;
        regWdata = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        foreach (pat[k]) begin
            boot(pat[k]);
            chk(defaults, pat[k]);
            chk(regulatorEnable, pat[k].regulatorStrap);
            chk(crossoverEnable, pat[k].crossoverStrap);
            rd(5'h10, {5'h00, pat[k].crossoverStrap, pat[k]});
            @(posedge clock);
            straps <= ~pat[k];
            for (int v = 0; v < 16; v++) begin
                @(posedge clock);
                coreStatus <= v[3:0];
                @(posedge clock);
                @(negedge clock);
                chk(indicatorOut, v[3:0]);
                chk(indicatorIn, v[3:0]);
            end
            chk(defaults, pat[k]);
            wr(5'h1b, 16'hffff);
            rd(5'h1b, 16'h8001);
            chk(crossoverEnable, 1'b0);
            chk(gpIn, 1'b1);
            wr(5'h1b, 16'h0000);
            rd(5'h05, 16'h0000);
            chk(crossoverEnable, pat[k].crossoverStrap);
            chk(gpIn, 1'b0);
        end
        reportAndStop();
    end
endmodule
`default_nettype wire
